// ### lps_pkg.sv
package lps_pkg;

    // Register offsets on the documented register port
    localparam logic [7:0] ADDR_INTEG_TIME = 8'h81;
    localparam logic [7:0] ADDR_WAIT_TIME = 8'h83;
    localparam logic [7:0] ADDR_LIGHT_LOW_LO = 8'h84;
    localparam logic [7:0] ADDR_LIGHT_LOW_HI = 8'h85;
    localparam logic [7:0] ADDR_LIGHT_HIGH_LO = 8'h86;
    localparam logic [7:0] ADDR_LIGHT_HIGH_HI = 8'h87;
    localparam logic [7:0] ADDR_PROX_LOW = 8'h89;
    localparam logic [7:0] ADDR_PROX_HIGH = 8'h8b;
    localparam logic [7:0] ADDR_PERSIST = 8'h8c;
    localparam logic [7:0] ADDR_ENABLE = 8'h80;
    localparam logic [7:0] ADDR_CONFIG1 = 8'h8d;
    localparam logic [7:0] ADDR_CLR_PROX = 8'he5;
    localparam logic [7:0] ADDR_CLR_LIGHT = 8'he6;
    localparam logic [7:0] ADDR_CLR_ALL = 8'he7;

    // Field positions
    localparam int BIT_LIGHT_MEAS_EN = 1;
    localparam int BIT_PROX_MEAS_EN = 2;
    localparam int BIT_LIGHT_IRQ_EN = 4;
    localparam int BIT_PROX_IRQ_EN = 5;
    localparam int BIT_LONG_WAIT = 1;
    localparam int PROX_PERSIST_LSB = 4;
    localparam int LIGHT_PERSIST_LSB = 0;

    // Reset values
    localparam logic [7:0] RST_INTEG_TIME = 8'hff;
    localparam logic [7:0] RST_WAIT_TIME = 8'hff;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_CONFIG1 = 8'h40;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int STEP_NS = 2_780_000;
    localparam int STEP_CYCLES_DEF = STEP_NS / 20;
    localparam int PROX_INTEG_NS = 696_000;
    localparam int PROX_CYCLES_DEF = PROX_INTEG_NS / 20;
    localparam logic [9:0] STEPS_FULL = 10'h100;
    localparam logic [3:0] LONG_WAIT_MULT = 4'hc;
    localparam logic [16:0] SAT_PER_STEP = 17'h00401;
    localparam logic [15:0] SAT_MAX = 16'hffff;

    // Measurement sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROX = 2'b01,
        ST_LIGHT = 2'b10,
        ST_WAIT = 2'b11
    } seq_state_t;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic addr_only;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Raw conversion samples from the analog front end
    typedef struct packed {
        logic [15:0] light;
        logic [7:0] prox;
    } sample_t;

endpackage

// ### light_prox_timing_and_threshold_irq.sv
`timescale 1ns/1ps
module light_prox_timing_and_threshold_irq
    import lps_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYCLES_DEF,
    parameter int PROX_CYCLES = PROX_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port
    input wire reg_req_t req,
    output logic [7:0] rdata,
    // Analog front end
    input wire sample_t sample,
    output logic prox_conv_done,
    output logic light_conv_done,
    output logic [15:0] clear_channel_result,
    output logic [7:0] prox_result,
    // Interrupt pin, active low
    output logic int_n
);

    // Timing overview
    //
    // The sequencer walks proximity, then light, then wait, and starts
    // again for as long as either measurement stays enabled. Every step
    // is counted off one shared tick divider, so each phase length is a
    // whole number of steps of STEP_CYCLES clocks. The one exception is
    // the proximity phase, which is a fixed PROX_CYCLES long.
    //
    // Leaving idle costs one clock, because the divider is zeroed there.
    // That cycle is not part of any phase the host can see.
    //
    // Limitation: changing the integration or wait field while a cycle
    // runs takes effect on the next step compare. A phase that is already
    // past its new end count runs on until the step counter wraps, so the
    // host should set both fields before enabling measurement.
    //
    // Interrupt overview
    //
    // Each channel owns its window test, its persistence counter and its
    // sticky flag. A done pulse is the only thing that can move a counter,
    // so a result on one channel never disturbs the other channel.
    //
    // The flags are sticky: a later in-range result leaves them alone and
    // only the matching address-only clear drops them. When a new event
    // and a clear meet in one clock the event wins, so no qualified event
    // is ever lost to a clear that the host issued a moment too early.
    //
    // The pin is the registered NOR of both flags. It follows a flag one
    // clock late, which costs a cycle but keeps the pin free of glitches.

    // Configuration registers
    logic [7:0] integ_time_field_r;
    logic [7:0] wait_time_field_r;
    logic [7:0] light_low_thr_lo_r, light_low_thr_hi_r;
    logic [7:0] light_high_thr_lo_r, light_high_thr_hi_r;
    logic [7:0] prox_low_thr_r, prox_high_thr_r;
    logic [7:0] persistence_reg_r;
    logic [7:0] enable_r;
    logic [7:0] config1_r;

    // Sequencer state, timing counters, persistence counters and interrupt flags
    seq_state_t state_r;
    logic [31:0] tick_r;
    logic [9:0] step_r;
    logic [3:0] mult_r;
    logic [5:0] prox_cnt_r, light_cnt_r;
    logic prox_irq_r, light_irq_r;

    // Decoded and combinational helpers
    logic step_end;
    logic light_meas_enable, prox_meas_enable;
    logic [9:0] integ_steps, wait_steps;
    logic [15:0] light_sat;
    logic prox_out, light_out;
    logic [5:0] prox_need, light_need;
    logic clr_prox, clr_light;
    logic [5:0] prox_cnt_nxt, light_cnt_nxt;

    // Step count for a field: 256 minus value, 0 gives 256
    function automatic logic [9:0] steps_of(input logic [7:0] f);
        steps_of = STEPS_FULL - {2'b00, f};
    endfunction

    // Persistence test: zero fires every cycle, else count reached
    function automatic logic persist_hit(input logic [5:0] need, input logic [5:0] cnt);
        persist_hit = (need == 6'h00) || (cnt >= need);
    endfunction

    assign light_meas_enable = enable_r[BIT_LIGHT_MEAS_EN];
    assign prox_meas_enable = enable_r[BIT_PROX_MEAS_EN];
    assign integ_steps = steps_of(integ_time_field_r);
    assign wait_steps = steps_of(wait_time_field_r);

    // Register writes; thresholds kept as separate bytes
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            integ_time_field_r <= RST_INTEG_TIME;
            wait_time_field_r <= RST_WAIT_TIME;
            light_low_thr_lo_r <= RST_ZERO;
            light_low_thr_hi_r <= RST_ZERO;
            light_high_thr_lo_r <= RST_ZERO;
            light_high_thr_hi_r <= RST_ZERO;
            prox_low_thr_r <= RST_ZERO;
            prox_high_thr_r <= RST_ZERO;
            persistence_reg_r <= RST_ZERO;
            enable_r <= RST_ENABLE;
            config1_r <= RST_CONFIG1;
        end else if (req.wr && !req.addr_only) begin
            case (req.addr)
                ADDR_INTEG_TIME: integ_time_field_r <= req.wdata;
                ADDR_WAIT_TIME: wait_time_field_r <= req.wdata;
                ADDR_LIGHT_LOW_LO: light_low_thr_lo_r <= req.wdata;
                ADDR_LIGHT_LOW_HI: light_low_thr_hi_r <= req.wdata;
                ADDR_LIGHT_HIGH_LO: light_high_thr_lo_r <= req.wdata;
                ADDR_LIGHT_HIGH_HI: light_high_thr_hi_r <= req.wdata;
                ADDR_PROX_LOW: prox_low_thr_r <= req.wdata;
                ADDR_PROX_HIGH: prox_high_thr_r <= req.wdata;
                ADDR_PERSIST: persistence_reg_r <= req.wdata;
                ADDR_ENABLE: enable_r <= req.wdata;
                ADDR_CONFIG1: config1_r <= req.wdata;
                default: ;
            endcase
        end
    end

    // Read data registered; unmapped addresses read zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_INTEG_TIME: rdata <= integ_time_field_r;
                ADDR_WAIT_TIME: rdata <= wait_time_field_r;
                ADDR_LIGHT_LOW_LO: rdata <= light_low_thr_lo_r;
                ADDR_LIGHT_LOW_HI: rdata <= light_low_thr_hi_r;
                ADDR_LIGHT_HIGH_LO: rdata <= light_high_thr_lo_r;
                ADDR_LIGHT_HIGH_HI: rdata <= light_high_thr_hi_r;
                ADDR_PROX_LOW: rdata <= prox_low_thr_r;
                ADDR_PROX_HIGH: rdata <= prox_high_thr_r;
                ADDR_PERSIST: rdata <= persistence_reg_r;
                ADDR_ENABLE: rdata <= enable_r;
                ADDR_CONFIG1: rdata <= config1_r;
                default: rdata <= 8'h00;
            endcase
        end
    end

    // Tick divider; proximity phase ends after PROX_CYCLES, not a full step
    assign step_end = (state_r == ST_PROX) ? (tick_r == 32'(PROX_CYCLES - 1))
                                           : (tick_r == 32'(STEP_CYCLES - 1));

    // Sequencer: prox, light, then wait, and around again
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            tick_r <= 32'h0;
            step_r <= 10'h0;
            mult_r <= 4'h0;
        end else begin
            tick_r <= step_end ? 32'h0 : tick_r + 32'h1;
            case (state_r)
                ST_IDLE: begin
                    tick_r <= 32'h0;
                    step_r <= 10'h0;
                    if (prox_meas_enable) begin
                        state_r <= ST_PROX;
                    end else if (light_meas_enable) begin
                        state_r <= ST_LIGHT;
                    end
                end
                ST_PROX: begin
                    if (step_end) begin
                        state_r <= light_meas_enable ? ST_LIGHT : ST_WAIT;
                        step_r <= 10'h0;
                        mult_r <= 4'h0;
                    end
                end
                ST_LIGHT: begin
                    if (step_end) begin
                        step_r <= step_r + 10'h1;
                        if (step_r + 10'h1 == integ_steps) begin
                            state_r <= ST_WAIT;
                            step_r <= 10'h0;
                            mult_r <= 4'h0;
                        end
                    end
                end
                ST_WAIT: begin
                    if (step_end) begin
                        // Each wait step repeats twelve times under long wait
                        if (config1_r[BIT_LONG_WAIT] && mult_r != LONG_WAIT_MULT - 4'h1) begin
                            mult_r <= mult_r + 4'h1;
                        end else begin
                            mult_r <= 4'h0;
                            step_r <= step_r + 10'h1;
                            if (step_r + 10'h1 == wait_steps) begin
                                step_r <= 10'h0;
                                if (prox_meas_enable) begin
                                    state_r <= ST_PROX;
                                end else if (light_meas_enable) begin
                                    state_r <= ST_LIGHT;
                                end else begin
                                    state_r <= ST_IDLE;
                                end
                            end
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign prox_conv_done = (state_r == ST_PROX) && step_end;
    assign light_conv_done = (state_r == ST_LIGHT) && step_end && (step_r + 10'h1 == integ_steps);

    // Saturation ceiling; wide product avoids wrap before the compare
    always_comb begin
        logic [26:0] prod;
        prod = 27'(SAT_PER_STEP) * 27'(integ_steps);
        light_sat = (prod > 27'(SAT_MAX)) ? SAT_MAX : prod[15:0];
    end

    // Results latched at end of each conversion
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clear_channel_result <= 16'h0;
            prox_result <= 8'h0;
        end else begin
            if (light_conv_done) begin
                clear_channel_result <= (sample.light > light_sat) ? light_sat : sample.light;
            end
            if (prox_conv_done) begin
                prox_result <= sample.prox;
            end
        end
    end

    // Window tests on the fresh sample and saturation
    always_comb begin
        logic [15:0] lv;
        lv = (sample.light > light_sat) ? light_sat : sample.light;
        light_out = (lv < {light_low_thr_hi_r, light_low_thr_lo_r})
                 || (lv > {light_high_thr_hi_r, light_high_thr_lo_r});
        prox_out = (sample.prox < prox_low_thr_r) || (sample.prox > prox_high_thr_r);
    end

    // Required consecutive counts; light scales by five above 3
    always_comb begin
        logic [3:0] pp, lp;
        pp = persistence_reg_r[PROX_PERSIST_LSB +: 4];
        lp = persistence_reg_r[LIGHT_PERSIST_LSB +: 4];
        prox_need = {2'b00, pp};
        if (lp < 4'h4) begin
            light_need = {2'b00, lp};
        end else begin
            light_need = 6'(({2'b00, lp} - 6'h3) * 6'h5);
        end
    end

    assign clr_prox = req.wr && req.addr_only && (req.addr == ADDR_CLR_PROX || req.addr == ADDR_CLR_ALL);
    assign clr_light = req.wr && req.addr_only && (req.addr == ADDR_CLR_LIGHT || req.addr == ADDR_CLR_ALL);

    // Count including this result; holding at 63 keeps a long run from
    // wrapping to zero and missing the compare after a clear
    assign prox_cnt_nxt = (prox_cnt_r == 6'h3f) ? prox_cnt_r : prox_cnt_r + 6'h1;
    assign light_cnt_nxt = (light_cnt_r == 6'h3f) ? light_cnt_r : light_cnt_r + 6'h1;

    // Independent persistence counters, saturating at 63
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prox_cnt_r <= 6'h0;
            light_cnt_r <= 6'h0;
        end else begin
            if (prox_conv_done) begin
                prox_cnt_r <= !prox_out ? 6'h0 : prox_cnt_nxt;
            end
            if (light_conv_done) begin
                light_cnt_r <= !light_out ? 6'h0 : light_cnt_nxt;
            end
        end
    end

    // Sticky interrupt flags; a new event wins over a clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prox_irq_r <= 1'b0;
            light_irq_r <= 1'b0;
        end else begin
            if (prox_conv_done && enable_r[BIT_PROX_IRQ_EN]
                && (prox_need == 6'h0 || (prox_out && persist_hit(prox_need, prox_cnt_nxt)))) begin
                prox_irq_r <= 1'b1;
            end else if (clr_prox) begin
                prox_irq_r <= 1'b0;
            end
            if (light_conv_done && enable_r[BIT_LIGHT_IRQ_EN]
                && (light_need == 6'h0 || (light_out && persist_hit(light_need, light_cnt_nxt)))) begin
                light_irq_r <= 1'b1;
            end else if (clr_light) begin
                light_irq_r <= 1'b0;
            end
        end
    end

    // Pin is a register so it never glitches
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            int_n <= 1'b1;
        end else begin
            int_n <= !(prox_irq_r || light_irq_r);
        end
    end

endmodule

// ### lps_front_end.sv
`timescale 1ns/1ps
module lps_front_end
    import lps_pkg::*;
(
    // Conversion strobes
    input wire logic prox_conv_done,
    input wire logic light_conv_done,
    // Scene values
    input wire logic [15:0] light_val,
    input wire logic [7:0] prox_val,
    // Converter outputs
    output sample_t sample
);
    // Inverse outside done, so a capture at the wrong moment shows up
    assign sample.light = light_conv_done ? light_val : ~light_val;
    assign sample.prox = prox_conv_done ? prox_val : ~prox_val;
endmodule

// ### lps_checker.sv
`timescale 1ns/1ps
module lps_checker
    import lps_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYCLES_DEF,
    parameter int PROX_CYCLES = PROX_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port
    input wire reg_req_t req,
    input wire logic [7:0] rdata,
    // Front end
    input wire sample_t sample,
    input wire logic prox_conv_done,
    input wire logic light_conv_done,
    input wire logic [15:0] clear_channel_result,
    input wire logic [7:0] prox_result,
    // Pin
    input wire logic int_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [7:0] integ_r;
    logic [31:0] gap_r;
    logic after_prox_r;
    wire [31:0] steps = 32'h100 - {24'h0, integ_r};
    wire [31:0] cap = (steps * 32'h401 > 32'hffff) ? 32'hffff : steps * 32'h401;
    wire clr = req.wr && req.addr_only && (req.addr inside {ADDR_CLR_PROX, ADDR_CLR_LIGHT, ADDR_CLR_ALL});
    wire clr_all = req.wr && req.addr_only && req.addr == ADDR_CLR_ALL;
    wire mapped = req.addr inside {8'h80, 8'h81, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h89, 8'h8b, 8'h8c, 8'h8d};
    // Shadow of the integration field, needed for the saturation limit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) integ_r <= RST_INTEG_TIME;
        else if (req.wr && !req.addr_only && req.addr == ADDR_INTEG_TIME) integ_r <= req.wdata;
    end
    // Cycles since the last proximity done, only meaningful while light follows it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) gap_r <= 32'h0;
        else if (prox_conv_done) gap_r <= 32'h1;
        else gap_r <= gap_r + 32'h1;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) after_prox_r <= 1'b0;
        else if (prox_conv_done) after_prox_r <= 1'b1;
        else if (light_conv_done) after_prox_r <= 1'b0;
    end
    chk_light_integ_len: assert property (
        light_conv_done && after_prox_r |-> gap_r == steps * STEP_CYCLES) else $error("light phase length wrong");
    chk_light_saturate: assert property (
        light_conv_done |=> {16'h0, clear_channel_result} ==
        (({16'h0, $past(sample.light)} > $past(cap)) ? $past(cap) : {16'h0, $past(sample.light)}))
        else $error("light result not limited");
    chk_prox_capture: assert property (
        prox_conv_done |=> prox_result == $past(sample.prox)) else $error("prox result not captured");
    chk_done_apart: assert property (
        !(prox_conv_done && light_conv_done)) else $error("both done pulses together");
    chk_int_hold: assert property (
        !int_n && !clr && !$past(clr) |=> !int_n) else $error("interrupt released without clear");
    chk_int_cause: assert property (
        $fell(int_n) |-> $past(prox_conv_done, 2) || $past(light_conv_done, 2)) else $error("interrupt without done");
    chk_clear_releases: assert property (
        clr_all && !prox_conv_done && !light_conv_done |-> ##2 int_n) else $error("clear all did not release");
    chk_unmapped_zero: assert property (
        req.rd && !mapped |=> rdata == 8'h00) else $error("unmapped read not zero");
    chk_wait_gap: assert property (
        light_conv_done |=> !prox_conv_done [*8]) else $error("no wait after light");
    cover property ($fell(int_n));
    cover property (light_conv_done && after_prox_r);
    cover property (req.wr && req.addr_only && req.addr == ADDR_CLR_PROX);
endmodule
bind light_prox_timing_and_threshold_irq lps_checker #(.STEP_CYCLES(STEP_CYCLES), .PROX_CYCLES(PROX_CYCLES)) lps_checker_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rdata(rdata), .sample(sample),
    .prox_conv_done(prox_conv_done), .light_conv_done(light_conv_done),
    .clear_channel_result(clear_channel_result), .prox_result(prox_result), .int_n(int_n));

// ### light_prox_timing_and_threshold_irq_bench.sv
`timescale 1ns/1ps
module light_prox_timing_and_threshold_irq_bench;
    import lps_pkg::*;
    localparam int SC = 8;
    localparam int PC = 2;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_t req = '0;
    sample_t sample;
    logic prox_conv_done, light_conv_done, int_n;
    logic [7:0] rdata, prox_result;
    logic [15:0] clear_channel_result;
    logic [15:0] light_val = 16'h0200;
    logic [7:0] prox_val = 8'h40;
    int n_fail = 0;
    int checked = 0;
    int n;
    // Rows: address, write data, readback
    logic [23:0] rows [11] = '{24'h81fdfd, 24'h83fefe, 24'h840000, 24'h850101, 24'h860000, 24'h870808,
        24'h891010, 24'h8b8080, 24'h8c3434, 24'h825a00, 24'he57700};
    always #10 clk_sys = ~clk_sys;
    light_prox_timing_and_threshold_irq #(.STEP_CYCLES(SC), .PROX_CYCLES(PC)) light_prox_timing_and_threshold_irq_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rdata(rdata), .sample(sample),
        .prox_conv_done(prox_conv_done), .light_conv_done(light_conv_done),
        .clear_channel_result(clear_channel_result), .prox_result(prox_result), .int_n(int_n));
    lps_front_end lps_front_end_i (.prox_conv_done(prox_conv_done), .light_conv_done(light_conv_done),
        .light_val(light_val), .prox_val(prox_val), .sample(sample));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle strobe, held until the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ao);
        @(posedge clk_sys);
        req <= '{wr: 1'b1, rd: 1'b0, addr_only: ao, addr: a, wdata: d};
        @(posedge clk_sys);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        req <= '{wr: 1'b0, rd: 1'b1, addr_only: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        req <= '0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask
    // Bounded wait for a done pulse; n holds the cycles it took
    task automatic pulse(input bit sel);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while ((sel ? light_conv_done : prox_conv_done) !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task automatic fire(input bit sel, input int need);
        for (int i = 1; i <= need; i++) begin
            pulse(sel);
            repeat (2) @(posedge clk_sys);
            #1 chk({15'h0, int_n}, {15'h0, i < need});
        end
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Whole run is well under two thousand cycles; this is ample
    initial begin
        #400000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        chk({15'h0, int_n}, 16'h0001);
        rd(ADDR_INTEG_TIME, 8'hff);
        rd(ADDR_WAIT_TIME, 8'hff);
        rd(ADDR_CONFIG1, 8'h40);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8], 1'b0);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        // Wait and integration are programmed above, before enabling
        light_val <= 16'hffff;
        wr(ADDR_ENABLE, 8'h06, 1'b0);
        pulse(0);
        pulse(0);
        chk(16'(n), 16'(PC + 3 * SC + 2 * SC));
        pulse(1);
        @(posedge clk_sys);
        #1 chk(clear_channel_result, 16'h0c03);
        wr(ADDR_CONFIG1, 8'h42, 1'b0);
        pulse(0);
        pulse(0);
        chk(16'(n), 16'(PC + 3 * SC + 24 * SC));
        wr(ADDR_CONFIG1, 8'h40, 1'b0);
        // Proximity: two outs, one in, then three outs are needed afresh
        light_val <= 16'h0200;
        wr(ADDR_ENABLE, 8'h36, 1'b0);
        pulse(0);
        prox_val <= 8'hf0;
        pulse(0);
        pulse(0);
        prox_val <= 8'h40;
        pulse(0);
        prox_val <= 8'hf0;
        fire(0, 3);
        prox_val <= 8'h40;
        pulse(0);
        repeat (2) @(posedge clk_sys);
        #1 chk({15'h0, int_n}, 16'h0000);
        wr(ADDR_CLR_ALL, 8'h00, 1'b0);
        repeat (3) @(posedge clk_sys);
        #1 chk({15'h0, int_n}, 16'h0000);
        wr(ADDR_CLR_PROX, 8'h00, 1'b1);
        repeat (2) @(posedge clk_sys);
        #1 chk({15'h0, int_n}, 16'h0001);
        // Light needs five while proximity stays in range every cycle
        pulse(1);
        light_val <= 16'h0a00;
        fire(1, 5);
        light_val <= 16'h0200;
        wr(ADDR_CLR_LIGHT, 8'h00, 1'b1);
        repeat (2) @(posedge clk_sys);
        #1 chk({15'h0, int_n}, 16'h0001);
        wr(ADDR_ENABLE, 8'h26, 1'b0);
        wr(ADDR_PERSIST, 8'h11, 1'b0);
        light_val <= 16'h0a00;
        repeat (3) pulse(1);
        repeat (2) @(posedge clk_sys);
        #1 chk({15'h0, int_n}, 16'h0001);
        wr(ADDR_PERSIST, 8'h01, 1'b0);
        fire(0, 1);
        chk({8'h00, prox_result}, 16'h0040);
        wr(ADDR_CLR_ALL, 8'h00, 1'b1);
        repeat (2) @(posedge clk_sys);
        #1 chk({15'h0, int_n}, 16'h0001);
        report_and_stop();
    end
endmodule
